//--- logic/ecc_event_counter_control.sv
`timescale 1ns/100ps
`include "ecc_consts.svh"

// How it works
// - async event three: fall, rise, zero passings
// - sync event three: two successive level samples
// - general zero passing sets suspend flag
// - general zero passing sets end flag
// - general counter reloads on zero passing
// - mode codes: never, idle-run, whole run
// - mode codes: detector, low, high level
// - bits 7:6 pick source zero to three
// - pair load condition: pin level select
// - low counter load enabled by zero
// - low counter reloads at zero passing
// - low counter edge and pin select
// - pair load trigger async or synchronised
// - arrangement: separate, tied, or 32-bit
// - high counter load enabled by zero, except in arrangement ECC_SEP_LOW_ONLY
// - high counter reloads at zero passing
// - high counter edge and pin select
// - bit C picks sync or async event three
module ecc_event_counter_control
  import ecc_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [3:0] event_pin_i,
  input wire logic [3:0] item_a_i,
  input wire logic run_command_i,
  input wire logic run_idle_i,
  output logic event_three_o,
  output logic suspend_req_o,
  output logic end_req_o,
  output logic gen_zero_o,
  output logic blo_zero_o,
  output logic bhi_zero_o
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_a_ff;
  logic rst_b_ff;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end
  wire logic rst_n = rst_b_ff;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic [3:0] pin_s3_ff;
  logic [3:0] pin_ff;
  logic [3:0] pin_prev_ff;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
      pin_s3_ff <= 4'h0;
      pin_ff <= 4'h0;
      pin_prev_ff <= 4'h0;
    end else begin
      pin_s1_ff <= event_pin_i;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_prev_ff <= pin_ff;
      for (int i = 0; i < 4; i++) begin
        if (pin_s2_ff[i] == pin_s3_ff[i]) begin
          pin_ff[i] <= pin_s3_ff[i];
        end
      end
    end
  end

  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_edge
      assign pin_rise[g] = pin_ff[g] & ~pin_prev_ff[g];
      assign pin_fall[g] = ~pin_ff[g] & pin_prev_ff[g];
    end
  endgenerate

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] ev3_ctrl_ff;
  logic [15:0] gen_ctrl_ff;
  logic [15:0] pair_ctrl_ff;
  logic [CW-1:0] gen_rld_ff;
  logic [CW-1:0] blo_rld_ff;
  logic [CW-1:0] bhi_rld_ff;
  logic [CW-1:0] gen_cnt_ff;
  logic [CW-1:0] blo_cnt_ff;
  logic [CW-1:0] bhi_cnt_ff;

  wire logic wr_ev3 = reg_wr_i && reg_addr_i == `ECC_ADDR_EV3;
  wire logic wr_gen = reg_wr_i && reg_addr_i == `ECC_ADDR_GEN;
  wire logic wr_pair = reg_wr_i && reg_addr_i == `ECC_ADDR_PAIR;
  // cmd bits: 0 load general, 1 load low, 2 load high
  wire logic wr_cmd = reg_wr_i && reg_addr_i == `ECC_ADDR_CMD;

  // one process per register; no reset value is known, so all clear
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ev3_ctrl_ff <= `ECC_CTRL_RST;
    end else if (wr_ev3) begin
      ev3_ctrl_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      gen_ctrl_ff <= `ECC_CTRL_RST;
    end else if (wr_gen) begin
      gen_ctrl_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pair_ctrl_ff <= `ECC_CTRL_RST;
    end else if (wr_pair) begin
      pair_ctrl_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      gen_rld_ff <= CW'(`ECC_CNT_RST);
    end else if (reg_wr_i && reg_addr_i == `ECC_ADDR_GEN_RLD) begin
      gen_rld_ff <= CW'(reg_wdata_i);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      blo_rld_ff <= CW'(`ECC_CNT_RST);
    end else if (reg_wr_i && reg_addr_i == `ECC_ADDR_BLO_RLD) begin
      blo_rld_ff <= CW'(reg_wdata_i);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      bhi_rld_ff <= CW'(`ECC_CNT_RST);
    end else if (reg_wr_i && reg_addr_i == `ECC_ADDR_BHI_RLD) begin
      bhi_rld_ff <= CW'(reg_wdata_i);
    end
  end

  // ****************************************
  // field decode
  // ****************************************
  ecc_gmode_t gmode;
  ecc_arr_t arr;
  logic [1:0] gsrc;
  logic [2:0] ldsel;
  logic [2:0] lo_edge;
  logic [2:0] hi_edge;
  logic [1:0] ev3_sel;
  assign gmode = ecc_gmode_t'(gen_ctrl_ff[`ECC_GEN_MODE_HI:`ECC_GEN_MODE_LO]);
  assign gsrc = gen_ctrl_ff[`ECC_GEN_SRC_HI:`ECC_GEN_SRC_LO];
  assign arr = ecc_arr_t'(pair_ctrl_ff[`ECC_PR_ARR_HI:`ECC_PR_ARR_LO]);
  assign ldsel = pair_ctrl_ff[`ECC_PR_LDSEL_HI:`ECC_PR_LDSEL_LO];
  assign lo_edge = pair_ctrl_ff[`ECC_PR_LO_EDGE_HI:`ECC_PR_LO_EDGE_LO];
  assign hi_edge = pair_ctrl_ff[`ECC_PR_HI_EDGE_HI:`ECC_PR_HI_EDGE_LO];
  assign ev3_sel = ev3_ctrl_ff[`ECC_EV3_SEL_HI:`ECC_EV3_SEL_LO];

  // ****************************************
  // general counter
  // ****************************************
  logic gen_cnt_en;
  always_comb begin
    case (gmode)
      ECC_GM_OFF0, ECC_GM_OFF1: gen_cnt_en = 1'b0;
      ECC_GM_IDLE: gen_cnt_en = run_command_i & run_idle_i;
      ECC_GM_RUN: gen_cnt_en = run_command_i;
      ECC_GM_DET0, ECC_GM_DET1: gen_cnt_en = item_a_i[gsrc];
      ECC_GM_LOW: gen_cnt_en = ~pin_ff[gsrc];
      ECC_GM_HIGH: gen_cnt_en = pin_ff[gsrc];
      default: gen_cnt_en = 1'b0;
    endcase
  end

  // zero passing: a count step taken from the value zero (wrap)
  wire logic gen_zp = gen_cnt_en && gen_cnt_ff == '0;
  // a command load wins over a zero-passing reload in the same cycle

  // ****************************************
  // counter pair
  // ****************************************
  // edge select: code[0] rising, code[2:1] pin
  wire logic lo_step = lo_edge[0] ? pin_rise[lo_edge[2:1]] : pin_fall[lo_edge[2:1]];
  wire logic hi_edge_ev = hi_edge[0] ? pin_rise[hi_edge[2:1]] :
                                       pin_fall[hi_edge[2:1]];
  // raw level on the chosen pin, or its synchronised copy
  wire logic ld_raw = pair_ctrl_ff[`ECC_PR_LDSYNC] ? pin_ff[ldsel[2:1]] :
                                                     pin_s3_ff[ldsel[2:1]];
  // load is level held: the pair, or only the low counter in ECC_SEP_LOW_ONLY, sits at reload values while true
  wire logic ld_trig = ld_raw == ldsel[0];
  wire logic lo_zp = lo_step && blo_cnt_ff == '0;
  wire logic wide = arr == ECC_WIDE || arr == ECC_TIED;
  // chained modes: high steps on low wrap; separate: own edge
  wire logic hi_step = wide ? lo_zp : hi_edge_ev;
  wire logic hi_zp = hi_step && bhi_cnt_ff == '0;
  wire logic lo_ld_ok = ~pair_ctrl_ff[`ECC_PR_LO_LDDIS];
  wire logic hi_ld_ok = ~pair_ctrl_ff[`ECC_PR_HI_LDDIS] && arr != ECC_SEP_LOW_ONLY;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      gen_cnt_ff <= CW'(`ECC_CNT_RST);
    end else if (wr_cmd && reg_wdata_i[0]) begin
      gen_cnt_ff <= gen_rld_ff;
    end else if (gen_zp && gen_ctrl_ff[`ECC_GEN_RLD]) begin
      gen_cnt_ff <= gen_rld_ff;
    end else if (gen_cnt_en) begin
      gen_cnt_ff <= gen_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      blo_cnt_ff <= CW'(`ECC_CNT_RST);
    end else if ((ld_trig || (wr_cmd && reg_wdata_i[1])) && lo_ld_ok) begin
      blo_cnt_ff <= blo_rld_ff;
    end else if (lo_zp && pair_ctrl_ff[`ECC_PR_LO_ZRLD]) begin
      blo_cnt_ff <= blo_rld_ff;
    end else if (lo_step) begin
      blo_cnt_ff <= blo_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      bhi_cnt_ff <= CW'(`ECC_CNT_RST);
    end else if ((ld_trig || (wr_cmd && reg_wdata_i[2])) && hi_ld_ok) begin
      bhi_cnt_ff <= bhi_rld_ff;
    end else if (hi_zp && pair_ctrl_ff[`ECC_PR_HI_ZRLD]) begin
      bhi_cnt_ff <= bhi_rld_ff;
    end else if (hi_step) begin
      bhi_cnt_ff <= bhi_cnt_ff - 1'b1;
    end
  end

  // ****************************************
  // event three recognition
  // ****************************************
  // sync mode looks at filtered levels, so a glitch shorter than
  // the filter window never counts
  logic ev3_hit;
  always_comb begin
    if (ev3_ctrl_ff[`ECC_EV3_SYNC]) begin
      case (ev3_sel)
        2'h0: ev3_hit = pin_prev_ff[3] & ~pin_ff[3];
        2'h1: ev3_hit = ~pin_prev_ff[3] & pin_ff[3];
        2'h2: ev3_hit = ~pin_prev_ff[3] & ~pin_ff[3];
        2'h3: ev3_hit = pin_prev_ff[3] & pin_ff[3];
        default: ev3_hit = 1'b0;
      endcase
    end else begin
      case (ev3_sel)
        2'h0: ev3_hit = pin_fall[3];
        2'h1: ev3_hit = pin_rise[3];
        2'h2: ev3_hit = lo_zp;
        2'h3: ev3_hit = hi_zp;
        default: ev3_hit = 1'b0;
      endcase
    end
  end

  // ****************************************
  // pulses and flags
  // ****************************************
  // set requests are registered pulses, event three held while a sync level pair lasts; holding and clearing live outside
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      event_three_o <= 1'b0;
    end else begin
      event_three_o <= ev3_hit;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      gen_zero_o <= 1'b0;
    end else begin
      gen_zero_o <= gen_zp;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      blo_zero_o <= 1'b0;
    end else begin
      blo_zero_o <= lo_zp;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      bhi_zero_o <= 1'b0;
    end else begin
      bhi_zero_o <= hi_zp;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      suspend_req_o <= 1'b0;
    end else begin
      suspend_req_o <= gen_zp && gen_ctrl_ff[`ECC_GEN_SUSP];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      end_req_o <= 1'b0;
    end else begin
      end_req_o <= gen_zp && gen_ctrl_ff[`ECC_GEN_END];
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // idle and unmapped cycles read as zero
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr_i)
      `ECC_ADDR_EV3: rd_mux = ev3_ctrl_ff;
      `ECC_ADDR_GEN: rd_mux = gen_ctrl_ff;
      `ECC_ADDR_PAIR: rd_mux = pair_ctrl_ff;
      `ECC_ADDR_GEN_RLD: rd_mux = 16'(gen_rld_ff);
      `ECC_ADDR_BLO_RLD: rd_mux = 16'(blo_rld_ff);
      `ECC_ADDR_BHI_RLD: rd_mux = 16'(bhi_rld_ff);
      `ECC_ADDR_GEN_CNT: rd_mux = 16'(gen_cnt_ff);
      `ECC_ADDR_BLO_CNT: rd_mux = 16'(blo_cnt_ff);
      `ECC_ADDR_BHI_CNT: rd_mux = 16'(bhi_cnt_ff);
      `ECC_ADDR_STAT: rd_mux = {12'h000, pin_ff};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule : ecc_event_counter_control

//--- logic/ecc_consts.svh
`ifndef ECC_CONSTS_SVH
`define ECC_CONSTS_SVH
// register offsets (plain port, word index)
`define ECC_ADDR_EV3 4'h0
`define ECC_ADDR_GEN 4'h1
`define ECC_ADDR_PAIR 4'h2
`define ECC_ADDR_GEN_RLD 4'h3
`define ECC_ADDR_BLO_RLD 4'h4
`define ECC_ADDR_BHI_RLD 4'h5
`define ECC_ADDR_GEN_CNT 4'h6
`define ECC_ADDR_BLO_CNT 4'h7
`define ECC_ADDR_BHI_CNT 4'h8
`define ECC_ADDR_STAT 4'h9
`define ECC_ADDR_CMD 4'ha
// event three control fields
`define ECC_EV3_SYNC 12
`define ECC_EV3_SEL_HI 15
`define ECC_EV3_SEL_LO 14
// general counter control fields
`define ECC_GEN_SUSP 0
`define ECC_GEN_END 1
`define ECC_GEN_RLD 2
`define ECC_GEN_MODE_HI 5
`define ECC_GEN_MODE_LO 3
`define ECC_GEN_SRC_HI 7
`define ECC_GEN_SRC_LO 6
// pair control fields
`define ECC_PR_LDSEL_HI 2
`define ECC_PR_LDSEL_LO 0
`define ECC_PR_LO_LDDIS 3
`define ECC_PR_LO_ZRLD 4
`define ECC_PR_LO_EDGE_HI 7
`define ECC_PR_LO_EDGE_LO 5
`define ECC_PR_LDSYNC 8
`define ECC_PR_ARR_HI 10
`define ECC_PR_ARR_LO 9
`define ECC_PR_HI_LDDIS 11
`define ECC_PR_HI_ZRLD 12
`define ECC_PR_HI_EDGE_HI 15
`define ECC_PR_HI_EDGE_LO 13
// reset values
`define ECC_CTRL_RST 16'h0000
`define ECC_CNT_RST 16'h0000
`endif

//--- logic/ecc_pkg.sv
package ecc_pkg;
  typedef enum logic [1:0] {ECC_SEP_LOW_ONLY, ECC_SEP_BOTH, ECC_TIED, ECC_WIDE} ecc_arr_t;
  typedef enum logic [2:0] {
    ECC_GM_OFF0, ECC_GM_OFF1, ECC_GM_IDLE, ECC_GM_RUN,
    ECC_GM_DET0, ECC_GM_DET1, ECC_GM_LOW, ECC_GM_HIGH
  } ecc_gmode_t;
endpackage : ecc_pkg

//--- testbench/ecc_event_counter_control_props.sv
`timescale 1ns/100ps
// ******************************
// control shadow and properties
// ******************************
module ecc_event_counter_control_chk (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [3:0] event_pin_i,
  input wire logic event_three_o,
  input wire logic suspend_req_o,
  input wire logic end_req_o,
  input wire logic gen_zero_o,
  input wire logic blo_zero_o
);
  logic [15:0] ctl_ff [3];
  logic [15:0] ev3;
  logic [15:0] gen;
  assign ev3 = ctl_ff[0];
  assign gen = ctl_ff[1];
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_ff <= '{default: 16'h0};
    end else if (reg_wr_i && reg_addr_i < 4'h3) begin
      ctl_ff[reg_addr_i[1:0]] <= reg_wdata_i;
    end
  end
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  chk_rd_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0)
    else $error("stray read data");
  chk_ctl_readback: assert property ($past(reg_rd_i) && $past(reg_addr_i) < 4'h3
    |-> reg_rdata_o == ctl_ff[$past(reg_addr_i[1:0])]) else $error("readback wrong");
  chk_susp_flag: assert property (suspend_req_o == (gen_zero_o && gen[0]))
    else $error("suspend request wrong");
  chk_end_flag: assert property (end_req_o == (gen_zero_o && gen[1]))
    else $error("end request wrong");
  chk_never_count: assert property ((gen[5:4] == 2'b00)[*3] |-> !gen_zero_o)
    else $error("counted in never mode");
  chk_gen_pulse: assert property (gen_zero_o |=> !gen_zero_o)
    else $error("general pulse too long");
  chk_low_pulse: assert property (blo_zero_o |=> !blo_zero_o)
    else $error("low pulse too long");
  chk_ev3_sync_on: assert property (
    (ev3[12] && ev3[15] && event_pin_i[3] == ev3[14])[*8] |-> event_three_o)
    else $error("level pair missed");
  chk_ev3_async_quiet: assert property (
    (!ev3[12] && !ev3[15] && $stable(event_pin_i[3]))[*8] |-> !event_three_o)
    else $error("event without edge");
endmodule : ecc_event_counter_control_chk

bind ecc_event_counter_control ecc_event_counter_control_chk u_chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .event_pin_i(event_pin_i), .event_three_o(event_three_o),
  .suspend_req_o(suspend_req_o), .end_req_o(end_req_o), .gen_zero_o(gen_zero_o),
  .blo_zero_o(blo_zero_o));

//--- testbench/ecc_board_model.sv
`timescale 1ns/100ps
// ******************************
// board event pins
// ******************************
module ecc_board_model (
  input wire logic [3:0] want_i,
  input wire logic slow_i,
  output logic [3:0] event_pin_o
);
  // pins move off the clock edge; slow lands several cycles late
  initial event_pin_o = 4'h0;
  always @(want_i) begin
    event_pin_o <= #(slow_i ? 430 : 30) want_i;
  end
endmodule : ecc_board_model

//--- testbench/event_counter_control_tb.sv
`timescale 1ns/100ps
module event_counter_control_tb;
  typedef struct {
    logic [15:0] ctl;
    logic [3:0] pin;
    logic [3:0] det;
    logic idle;
    logic cnt;
  } ecc_row_t;
  ecc_row_t rows [10] = '{
    '{16'h0004, 4'h0, 4'h0, 1'b1, 1'b0}, '{16'h000c, 4'h0, 4'h0, 1'b1, 1'b0},
    '{16'h001c, 4'h0, 4'h0, 1'b0, 1'b1}, '{16'h0014, 4'h0, 4'h0, 1'b0, 1'b0},
    '{16'h0014, 4'h0, 4'h0, 1'b1, 1'b1}, '{16'h00bc, 4'h4, 4'h0, 1'b0, 1'b1},
    '{16'h00b4, 4'h0, 4'h0, 1'b0, 1'b1}, '{16'h0064, 4'h0, 4'h2, 1'b0, 1'b1},
    '{16'h002c, 4'h0, 4'h1, 1'b0, 1'b1}, '{16'h00f4, 4'h8, 4'h0, 1'b0, 1'b0}};
  logic [3:0] edg [3] = '{4'h2, 4'h0, 4'h2};
  logic [20:0] ev [4] = '{21'h184000, 21'h18d000, 21'h089000, 21'h100000};
  logic clk_sys_i;
  logic nrst_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [3:0] want = 4'h0;
  logic slow = 1'b0;
  logic [3:0] item_a_i = 4'h0;
  logic run_command_i = 1'b0;
  logic run_idle_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic [3:0] event_pin_i;
  logic event_three_o, suspend_req_o, end_req_o, gen_zero_o, blo_zero_o, bhi_zero_o;
  logic [3:0] hits;
  int n, num_errors, n_tests;
  assign hits = {bhi_zero_o, event_three_o, blo_zero_o, gen_zero_o};
  ecc_event_counter_control u_ecc_event_counter_control (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .event_pin_i(event_pin_i), .item_a_i(item_a_i), .run_command_i(run_command_i),
    .run_idle_i(run_idle_i), .event_three_o(event_three_o), .suspend_req_o(suspend_req_o),
    .end_req_o(end_req_o), .gen_zero_o(gen_zero_o), .blo_zero_o(blo_zero_o),
    .bhi_zero_o(bhi_zero_o));
  ecc_board_model u_ecc_board_model (.want_i(want), .slow_i(slow), .event_pin_o(event_pin_i));
  // ******************************
  // bus and check tasks
  // ******************************
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rdc(input string nm, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #10;
    check(nm, reg_rdata_o, exp);
    @(posedge clk_sys_i);
  endtask : rdc
  // n is left at lim when nothing was seen
  task automatic wait_hit(input int s, input int lim);
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (hits[s] !== 1'b1 && n < lim);
  endtask : wait_hit
  task automatic complete_run();
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #500000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    run_command_i <= 1'b1;
    wr(4'h3, 16'h0002);
    wr(4'ha, 16'h0001);
    foreach (rows[i]) begin
      @(posedge clk_sys_i);
      want <= rows[i].pin;
      item_a_i <= rows[i].det;
      run_idle_i <= rows[i].idle;
      repeat (8) @(posedge clk_sys_i);
      wr(4'h1, rows[i].ctl);
      repeat (2) @(posedge clk_sys_i);
      wait_hit(0, 20);
      check("gen count", 16'(n < 20), 16'(rows[i].cnt));
    end
    wr(4'h1, 16'h001f);
    wait_hit(0, 20);
    check("flags", {14'h0, suspend_req_o, end_req_o}, 16'h3);
    wait_hit(0, 20);
    check("period", 16'(n), 16'h3);
    wr(4'h1, 16'h001c);
    repeat (2) @(posedge clk_sys_i);
    wait_hit(0, 20);
    check("no flags", {14'h0, suspend_req_o, end_req_o}, 16'h0);
    // ******************************
    // second counter pair and event three
    // ******************************
    wr(4'h4, 16'h0001);
    wr(4'h2, 16'h0071);
    wr(4'ha, 16'h0002);
    foreach (edg[k]) begin
      @(posedge clk_sys_i);
      want <= edg[k];
      wait_hit(1, 12);
      check("low zero", 16'(n < 12), 16'(k == 2));
    end
    rdc("low reload", 4'h7, 16'h0001);
    wr(4'h4, 16'h0005);
    wr(4'h2, 16'h0079);
    wr(4'ha, 16'h0002);
    rdc("load off", 4'h7, 16'h0001);
    wr(4'h2, 16'h0071);
    wr(4'ha, 16'h0002);
    rdc("load on", 4'h7, 16'h0005);
    wr(4'h4, 16'h0003);
    wr(4'h2, 16'h0173);
    rdc("pin load", 4'h7, 16'h0003);
    wr(4'h2, 16'hffff);
    rdc("pair ctl", 4'h2, 16'hffff);
    wr(4'hb, 16'h1234);
    rdc("unmapped", 4'hb, 16'h0000);
    slow <= 1'b1;
    foreach (ev[k]) begin
      wr(4'h0, ev[k][15:0]);
      want <= ev[k][19:16];
      repeat (2) @(posedge clk_sys_i);
      wait_hit(2, 20);
      check("event three", 16'(n < 20), 16'(ev[k][20]));
      repeat (8) @(posedge clk_sys_i);
    end
    wr(4'h4, 16'h0000);
    wr(4'h5, 16'h0000);
    wr(4'h2, 16'h1671);
    wr(4'ha, 16'h0006);
    @(posedge clk_sys_i);
    want <= 4'h2;
    wait_hit(3, 20);
    check("high chain", 16'(n < 20), 16'h0001);
    rdc("high count", 4'h8, 16'h0000);
    wr(4'h5, 16'h0009);
    wr(4'h2, 16'h1e71);
    wr(4'ha, 16'h0004);
    rdc("high load off", 4'h8, 16'h0000);
    wr(4'h2, 16'h1671);
    wr(4'ha, 16'h0004);
    rdc("high load on", 4'h8, 16'h0009);
    wr(4'h2, 16'h3277);
    @(posedge clk_sys_i);
    want <= 4'h3;
    repeat (12) @(posedge clk_sys_i);
    rdc("high edge", 4'h8, 16'h0008);
    nrst_i <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
    check("reset outs", {10'h0, hits, suspend_req_o, end_req_o}, 16'h0);
    @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    for (int a = 0; a < 3; a++) begin
      rdc("reset value", 4'(a), 16'h0000);
    end
    complete_run();
  end
endmodule : event_counter_control_tb
